// >>> hdl/sbc_pkg.sv
package sbc_pkg;

    // Register offsets
    localparam logic [15:0] SLIP_BUFFER_CONTROL_ADDR = 16'h0116;
    localparam logic [15:0] FIFO_LATENCY_ADDR = 16'h0117;
    localparam logic [15:0] STATUS_ADDR = 16'h0118;

    // Slip buffer control field positions
    localparam int TX_FIFO_BIT = 7;
    localparam int FORCE_FREEZE_BIT = 4;
    localparam int SLIP_FREEZE_BIT = 3;
    localparam int SYNC_DIR_BIT = 2;

    // Reset values
    localparam logic [7:0] SLIP_BUFFER_CONTROL_RESET = 8'h05;
    localparam logic [4:0] FIFO_LATENCY_RESET = 5'h04;

    // Receive buffer mode encodings
    localparam logic [1:0] RX_MODE_BYPASS0 = 2'h0;
    localparam logic [1:0] RX_MODE_SLIP = 2'h1;
    localparam logic [1:0] RX_MODE_FIFO = 2'h2;
    localparam logic [1:0] RX_MODE_BYPASS3 = 2'h3;

    // Multiframe length in rx serial clock periods
    localparam logic [12:0] MULTIFRAME_BITS = 13'h1000;

    typedef struct packed {
        logic tx_buffer_fifo_select;
        logic force_signaling_freeze;
        logic slip_freeze_enable;
        logic rx_sync_direction;
        logic [1:0] rx_buffer_mode;
        logic [4:0] fifo_latency;
    } sbc_cfg_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbc_bus_type;

endpackage

// >>> hdl/sbc_edge.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Asynchronous input and its rising edge
    input wire logic async_in,
    output logic level,
    output logic rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sbc_edge_state_type;

    sbc_edge_state_type st_r;
    sbc_edge_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s2;
    assign rise = st_r.s2 & ~st_r.s3;

endmodule // sbc_edge

`default_nettype wire

// >>> hdl/sbc_slip_buffer_control.sv
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module sbc_slip_buffer_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Receive side events and clock
    input wire logic rx_serial_clock_in,
    input wire logic rx_slip_event,
    // Pin directions, high means device drives the pin
    output logic rx_serial_clock_oe,
    output logic rx_frame_boundary_oe,
    output logic tx_serial_clock_oe,
    // Configuration to the elastic stores
    output logic tx_buffer_fifo_select,
    output logic rx_buffer_bypass,
    output logic rx_buffer_fifo,
    output logic [4:0] rx_latency,
    output logic [4:0] tx_latency,
    // Signaling update permission
    output logic signaling_update_enable
);

    typedef struct packed {
        sbc_pkg::sbc_cfg_type cfg;
        logic slip_freeze;
        logic slip_pending;
        logic [12:0] mf_count;
        logic [7:0] rdata;
        logic rx_serial_clock_oe;
        logic rx_frame_boundary_oe;
        logic tx_serial_clock_oe;
        logic tx_fifo;
        logic rx_bypass;
        logic rx_fifo;
        logic [4:0] rx_latency;
        logic [4:0] tx_latency;
        logic update_enable;
    } sbc_state_type;

    sbc_state_type st_r;
    sbc_state_type st_nxt;
    logic rx_clk_level;
    logic rx_clk_rise;
    logic slip_level;
    logic slip_rise;

    // Rx serial clock sampled and edge detected
    sbc_edge u_rx_clk (
        .clk(clk),
        .reset(reset),
        .async_in(rx_serial_clock_in),
        .level(rx_clk_level),
        .rise(rx_clk_rise)
    );

    // Slip indication from the receive store domain
    sbc_edge u_slip (
        .clk(clk),
        .reset(reset),
        .async_in(rx_slip_event),
        .level(slip_level),
        .rise(slip_rise)
    );

    function automatic sbc_pkg::sbc_cfg_type cfg_reset();
        sbc_pkg::sbc_cfg_type c;
        c.tx_buffer_fifo_select = sbc_pkg::SLIP_BUFFER_CONTROL_RESET[sbc_pkg::TX_FIFO_BIT];
        c.force_signaling_freeze = sbc_pkg::SLIP_BUFFER_CONTROL_RESET[sbc_pkg::FORCE_FREEZE_BIT];
        c.slip_freeze_enable = sbc_pkg::SLIP_BUFFER_CONTROL_RESET[sbc_pkg::SLIP_FREEZE_BIT];
        c.rx_sync_direction = sbc_pkg::SLIP_BUFFER_CONTROL_RESET[sbc_pkg::SYNC_DIR_BIT];
        c.rx_buffer_mode = sbc_pkg::SLIP_BUFFER_CONTROL_RESET[1:0];
        c.fifo_latency = sbc_pkg::FIFO_LATENCY_RESET;
        return c;
    endfunction

    function automatic logic [7:0] control_word(sbc_pkg::sbc_cfg_type c);
        logic [7:0] w;
        w = 8'h00;
        w[sbc_pkg::TX_FIFO_BIT] = c.tx_buffer_fifo_select;
        w[sbc_pkg::FORCE_FREEZE_BIT] = c.force_signaling_freeze;
        w[sbc_pkg::SLIP_FREEZE_BIT] = c.slip_freeze_enable;
        w[sbc_pkg::SYNC_DIR_BIT] = c.rx_sync_direction;
        w[1:0] = c.rx_buffer_mode;
        return w;
    endfunction

    logic bypass_c;
    logic fifo_c;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;

        // Register writes
        if (wr) begin
            case (addr)
                sbc_pkg::SLIP_BUFFER_CONTROL_ADDR: begin
                    st_nxt.cfg.tx_buffer_fifo_select = wdata[sbc_pkg::TX_FIFO_BIT];
                    st_nxt.cfg.force_signaling_freeze = wdata[sbc_pkg::FORCE_FREEZE_BIT];
                    st_nxt.cfg.slip_freeze_enable = wdata[sbc_pkg::SLIP_FREEZE_BIT];
                    st_nxt.cfg.rx_sync_direction = wdata[sbc_pkg::SYNC_DIR_BIT];
                    st_nxt.cfg.rx_buffer_mode = wdata[1:0];
                end
                sbc_pkg::FIFO_LATENCY_ADDR: begin
                    st_nxt.cfg.fifo_latency = wdata[4:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data one cycle later
        if (rd) begin
            case (addr)
                sbc_pkg::SLIP_BUFFER_CONTROL_ADDR: st_nxt.rdata = control_word(st_r.cfg);
                sbc_pkg::FIFO_LATENCY_ADDR: st_nxt.rdata = {3'h0, st_r.cfg.fifo_latency};
                sbc_pkg::STATUS_ADDR: begin
                    st_nxt.rdata = {5'h00, st_r.slip_pending, st_r.slip_freeze,
                                    st_r.update_enable};
                end
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // Slip freeze lasts one multiframe of rx serial clocks; a new slip restarts it
        if (st_r.slip_freeze && rx_clk_rise) begin
            if (st_r.mf_count == 13'h0001) begin
                st_nxt.slip_freeze = 1'b0;
            end
            st_nxt.mf_count = st_r.mf_count - 13'h0001;
        end
        if (!st_r.cfg.slip_freeze_enable) begin
            st_nxt.slip_freeze = 1'b0;
        end
        if (slip_rise && st_r.cfg.slip_freeze_enable) begin
            st_nxt.slip_freeze = 1'b1;
            st_nxt.mf_count = sbc_pkg::MULTIFRAME_BITS;
        end
        st_nxt.slip_pending = slip_level;

        // Both freezes must end before updates resume
        st_nxt.update_enable = ~st_nxt.cfg.force_signaling_freeze
                               & ~st_nxt.slip_freeze;

        bypass_c = (st_nxt.cfg.rx_buffer_mode == sbc_pkg::RX_MODE_BYPASS0)
                   || (st_nxt.cfg.rx_buffer_mode == sbc_pkg::RX_MODE_BYPASS3);
        fifo_c = (st_nxt.cfg.rx_buffer_mode == sbc_pkg::RX_MODE_FIFO);
        st_nxt.rx_bypass = bypass_c;
        st_nxt.rx_fifo = fifo_c;
        st_nxt.rx_serial_clock_oe = bypass_c;
        if (bypass_c) begin
            st_nxt.rx_frame_boundary_oe = 1'b1;
        end else begin
            st_nxt.rx_frame_boundary_oe = ~st_nxt.cfg.rx_sync_direction;
        end

        // Tx serial clock always an input to the elastic store
        st_nxt.tx_serial_clock_oe = 1'b0;
        st_nxt.tx_fifo = st_nxt.cfg.tx_buffer_fifo_select;
        st_nxt.tx_latency = st_nxt.cfg.tx_buffer_fifo_select ?
                            st_nxt.cfg.fifo_latency : 5'h00;
        st_nxt.rx_latency = fifo_c ? st_nxt.cfg.fifo_latency : 5'h00;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r.cfg <= cfg_reset();
            st_r.slip_freeze <= 1'b0;
            st_r.slip_pending <= 1'b0;
            st_r.mf_count <= 13'h0000;
            st_r.rdata <= 8'h00;
            st_r.rx_serial_clock_oe <= 1'b0;
            st_r.rx_frame_boundary_oe <= 1'b0;
            st_r.tx_serial_clock_oe <= 1'b0;
            st_r.tx_fifo <= 1'b0;
            st_r.rx_bypass <= 1'b0;
            st_r.rx_fifo <= 1'b0;
            st_r.rx_latency <= 5'h00;
            st_r.tx_latency <= 5'h00;
            st_r.update_enable <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign rx_serial_clock_oe = st_r.rx_serial_clock_oe;
    assign rx_frame_boundary_oe = st_r.rx_frame_boundary_oe;
    assign tx_serial_clock_oe = st_r.tx_serial_clock_oe;
    assign tx_buffer_fifo_select = st_r.tx_fifo;
    assign rx_buffer_bypass = st_r.rx_bypass;
    assign rx_buffer_fifo = st_r.rx_fifo;
    assign rx_latency = st_r.rx_latency;
    assign tx_latency = st_r.tx_latency;
    assign signaling_update_enable = st_r.update_enable;

endmodule // sbc_slip_buffer_control

`default_nettype wire

// >>> tb/sbc_backplane_model.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_backplane_model (
    // Control from the bench
    input wire logic run,
    input wire logic slip,
    // Backplane lines
    output logic rx_serial_clock,
    output logic rx_slip_event
);
    initial rx_serial_clock = 1'b0;
    // Clock only while run is high, edges on device clock falling edges
    always #100 if (run) rx_serial_clock = ~rx_serial_clock;
    assign rx_slip_event = slip;
endmodule // sbc_backplane_model

`default_nettype wire

// >>> tb/sbc_slip_buffer_control_sva.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_slip_buffer_control_sva (
    // Watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rx_serial_clock_oe,
    input wire logic rx_frame_boundary_oe,
    input wire logic tx_serial_clock_oe,
    input wire logic tx_buffer_fifo_select,
    input wire logic rx_buffer_bypass,
    input wire logic rx_buffer_fifo,
    input wire logic [4:0] rx_latency,
    input wire logic signaling_update_enable
);
    logic wc;
    assign wc = wr && (addr == sbc_pkg::SLIP_BUFFER_CONTROL_ADDR);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    tx_clk_in_a: assert property (!tx_serial_clock_oe)
        else $error("tx serial clock driven");
    bypass_pins_a: assert property (
        rx_buffer_bypass |-> rx_serial_clock_oe && rx_frame_boundary_oe)
        else $error("bypass pin direction wrong");
    store_clk_a: assert property (!rx_buffer_bypass |-> !rx_serial_clock_oe)
        else $error("rx clock not input");
    lat_ignored_a: assert property (!rx_buffer_fifo |-> rx_latency == 5'h00)
        else $error("latency outside fifo mode");
    mode_decode_a: assert property (
        wc |=> rx_buffer_bypass == ($past(wdata[0]) == $past(wdata[1])))
        else $error("bypass decode wrong");
    tx_mode_a: assert property (wc |=> tx_buffer_fifo_select == $past(wdata[7]))
        else $error("tx mode wrong");
    force_freeze_a: assert property (wc && wdata[4] |=> !signaling_update_enable)
        else $error("forced freeze not applied");
    sync_dir_a: assert property (
        wc && wdata[1:0] == 2'h1 |=> rx_frame_boundary_oe == !$past(wdata[2]))
        else $error("sync direction wrong");
    lat_write_a: assert property (wr && addr == sbc_pkg::FIFO_LATENCY_ADDR && rx_buffer_fifo
        |=> rx_latency == $past(wdata[4:0]))
        else $error("latency not applied");
    c_fifo_c: cover property (rx_buffer_fifo);
    c_bypass_c: cover property (rx_buffer_bypass);
    c_freeze_c: cover property ($fell(signaling_update_enable));
endmodule // sbc_slip_buffer_control_sva

bind sbc_slip_buffer_control sbc_slip_buffer_control_sva sva_u (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rx_serial_clock_oe(rx_serial_clock_oe),
    .rx_frame_boundary_oe(rx_frame_boundary_oe), .tx_serial_clock_oe(tx_serial_clock_oe),
    .tx_buffer_fifo_select(tx_buffer_fifo_select), .rx_buffer_bypass(rx_buffer_bypass),
    .rx_buffer_fifo(rx_buffer_fifo), .rx_latency(rx_latency),
    .signaling_update_enable(signaling_update_enable));

`default_nettype wire

// >>> tb/tb_slip_buffer_control.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end

module tb_slip_buffer_control;
    logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, slip = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata;
    logic sclk, slev, sc_oe, fb_oe, tx_oe, tx_fifo, byp, rx_fifo, upd;
    logic [4:0] rx_lat, tx_lat;
    int err_count = 0, check_count = 0;
    localparam logic [15:0] CA = sbc_pkg::SLIP_BUFFER_CONTROL_ADDR;
    localparam logic [15:0] LA = sbc_pkg::FIFO_LATENCY_ADDR;

    sbc_backplane_model bp_u (.run(run), .slip(slip), .rx_serial_clock(sclk),
        .rx_slip_event(slev));
    sbc_slip_buffer_control dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_serial_clock_in(sclk), .rx_slip_event(slev),
        .rx_serial_clock_oe(sc_oe), .rx_frame_boundary_oe(fb_oe), .tx_serial_clock_oe(tx_oe),
        .tx_buffer_fifo_select(tx_fifo), .rx_buffer_bypass(byp), .rx_buffer_fifo(rx_fifo),
        .rx_latency(rx_lat), .tx_latency(tx_lat), .signaling_update_enable(upd));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask

    task automatic t_reset;
        rd_chk(CA, 8'h05);
        rd_chk(LA, 8'h04);
        `CHK("fb_oe", 1'b0, fb_oe)
    endtask

    task automatic t_modes;
        logic e_byp;
        wr_reg(LA, 8'h13);
        for (int m = 0; m < 8; m++) begin
            e_byp = (m[1:0] == 2'h0) || (m[1:0] == 2'h3);
            wr_reg(CA, {m[0], 4'h0, m[2], m[1:0]});
            `CHK("tx_fifo", m[0], tx_fifo)
            `CHK("tx_lat", m[0] ? 5'h13 : 5'h00, tx_lat)
            `CHK("bypass", e_byp, byp)
            `CHK("sc_oe", e_byp, sc_oe)
            `CHK("fb_oe", e_byp | ~m[2], fb_oe)
            `CHK("rx_lat", m[1:0] == 2'h2 ? 5'h13 : 5'h00, rx_lat)
            `CHK("rx_fifo", m[1:0] == 2'h2, rx_fifo)
            `CHK("tx_oe", 1'b0, tx_oe)
        end
        wr_reg(16'h0119, 8'hFF);
        rd_chk(16'h0119, 8'h00);
        rd_chk(LA, 8'h13);
        rd_chk(CA, 8'h87);
    endtask

    task automatic t_force;
        wr_reg(CA, 8'h15);
        `CHK("upd", 1'b0, upd)
        rd_chk(sbc_pkg::STATUS_ADDR, 8'h00);
        wr_reg(CA, 8'h05);
        `CHK("upd", 1'b1, upd)
        rd_chk(sbc_pkg::STATUS_ADDR, 8'h01);
    endtask

    task automatic pulse_slip(input logic en);
        wr_reg(CA, en ? 8'h0D : 8'h05);
        @(posedge clk) slip <= 1'b1;
        repeat (8) @(posedge clk);
        slip <= 1'b0;
        #1 `CHK("upd", ~en, upd)
    endtask

    task automatic t_slip;
        pulse_slip(1'b0);
        pulse_slip(1'b1);
        run = 1'b1;
        repeat (4090) @(posedge sclk);
        @(posedge clk) #1 `CHK("upd", 1'b0, upd)
        repeat (12) @(posedge sclk);
        @(posedge clk) #1 `CHK("upd", 1'b1, upd)
        pulse_slip(1'b1);
        wr_reg(CA, 8'h1D);
        wr_reg(CA, 8'h0D);
        `CHK("upd", 1'b0, upd)
        wr_reg(CA, 8'h1D);
        repeat (4110) @(posedge sclk);
        @(posedge clk) #1 `CHK("upd", 1'b0, upd)
        wr_reg(CA, 8'h0D);
        `CHK("upd", 1'b1, upd)
        run = 1'b0;
    endtask

    task automatic close_out;
        if (err_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #2_400_000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_force();
        t_slip();
        close_out();
    end
endmodule // tb_slip_buffer_control

`default_nettype wire
